// ==== rtl/ufc_pkg.sv ====
package ufc_pkg;
  // Register byte offsets (one aligned 32-bit word each)
  localparam logic [7:0] ADDR_DATA = 8'h00;  // Holding regs / divisor low
  localparam logic [7:0] ADDR_IER = 8'h04;   // Int enable / divisor high
  localparam logic [7:0] ADDR_ISR = 8'h08;   // Read: ident, write: FIFO setup
  localparam logic [7:0] ADDR_LCR = 8'h0c;
  localparam logic [7:0] ADDR_MCR = 8'h10;
  localparam logic [7:0] ADDR_LSR = 8'h14;
  localparam logic [7:0] ADDR_MSR = 8'h18;
  localparam logic [7:0] ADDR_ENH = 8'h1c;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] ENH_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // Field positions
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMA = 3;
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EVEN = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BREAK = 6;
  localparam int LCR_DIV = 7;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_IRPOL = 2;
  localparam int MCR_LOOP = 4;
  localparam int MCR_IRDA = 6;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LSR = 2;
  localparam int IER_MSR = 3;
  localparam int IER_XOFF = 5;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  localparam int ENH_EN = 4;

  // Identification codes, bits 5:0
  localparam logic [5:0] ISR_LSR = 6'h06;
  localparam logic [5:0] ISR_TO = 6'h0c;
  localparam logic [5:0] ISR_RX = 6'h04;
  localparam logic [5:0] ISR_TX = 6'h02;
  localparam logic [5:0] ISR_MSR = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  localparam logic [5:0] ISR_NONE = 6'h01;

  // Receive idle timeout: chars plus bits
  localparam logic [6:0] TO_CHARS = 7'h04;
  localparam logic [6:0] TO_BITS = 7'h0c;

  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = 5'h01;
      2'h1: trig_level = 5'h04;
      2'h2: trig_level = 5'h08;
      default: trig_level = 5'h0e;
    endcase
  endfunction : trig_level
endpackage : ufc_pkg

// ==== rtl/ufc_uart_ctrl.sv ====
// How it works
// - Line status read clears its interrupt.
// - Receive interrupt holds while count at or above trigger.
// - Receive holding read clears timeout interrupt.
// - Ident read of transmit code or transmit write clears transmit.
// - Modem status read clears modem, flow interrupts.
// - Xoff/special cleared by ident read of its code, Xon, char.
// - Ident returns highest priority pending code only.
// - Ident bit 0 low when something pending.
// - Bits 4, 5 only with enhanced enable.
// - Ident bits 7:6 mirror FIFO enable.
// - Other FIFO setup bits ignored unless bit 0 set.
// - Pointer reset bits pulse once, self clear.
// - FIFO setup bit 3 selects DMA pins.
// - Transmit trigger 1/4/8/14, fires falling below.
// - Receive trigger 1/4/8/14 selects interrupt level.
// - Line format bits 1:0 set length.
// - Stop bits one, one and a half or two.
// - Parity none, odd, even, mark, space.
// - Break bit holds serial output low.
// - Line format bit 7 selects divisor latches.
// - DTR and RTS outputs are inverted bits.
// - Bit 2 sets IR polarity, loopback ring.
// - Timeout after four chars plus twelve bits.
`timescale 1ns/1ps
`default_nettype none
module ufc_uart_ctrl #(
  parameter int FIFO_DEPTH = 16,
  parameter int COUNT_W = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] rxHoldData,
  input wire logic [7:0] lineStatus,
  input wire logic [7:0] modemStatus,
  input wire logic [COUNT_W-1:0] rxCount,
  input wire logic [COUNT_W-1:0] txCount,
  input wire logic rxCharEvent,
  input wire logic rxActivity,
  input wire logic lineErrEvent,
  input wire logic modemDeltaEvent,
  input wire logic xoffMatch,
  input wire logic xonMatch,
  input wire logic specialMatch,
  input wire logic flowDeassert,
  input wire logic bitTick,
  input wire logic txSerial,
  input wire logic [7:0] txParityData,
  input wire logic [7:0] rxParityData,
  input wire logic rxParityBit,
  input wire logic ringIndicatorInN,
  input wire logic irdaRxIn,
  output logic rxHoldRead,
  output logic txHoldWrite,
  output logic [7:0] txHoldData,
  output logic rxFifoReset,
  output logic txFifoReset,
  output logic fifoEnable,
  output logic [3:0] dataBits,
  output logic [2:0] stopHalfBits,
  output logic parityEnable,
  output logic txParityBit,
  output logic rxParityError,
  output logic txPin,
  output logic dtrN,
  output logic rtsN,
  output logic txReadyN,
  output logic rxReadyN,
  output logic irdaRxData,
  output logic loopback,
  output logic ringStatus,
  output logic [15:0] divisor
);
  if (COUNT_W < 5 || FIFO_DEPTH < 14 || FIFO_DEPTH >= (1 << COUNT_W)) begin
    $error("FIFO_DEPTH or COUNT_W out of range");
  end

  typedef struct packed {
    logic awPend;
    logic [7:0] awAddr;
    logic wPend;
    logic [7:0] wData;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    logic [7:0] ier;
    logic [7:0] line_format;
    logic [7:0] modem_output_control;
    logic [7:0] enh;
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic fifoEn;
    logic dma;
    logic [1:0] txTrig;
    logic [1:0] rxTrig;
    logic lsrInt;
    logic toInt;
    logic txInt;
    logic msrInt;
    logic xoffInt;
    logic specInt;
    logic flowInt;
    logic txOver;
    logic [6:0] toCount;
    logic [COUNT_W-1:0] txPrev;
    logic rxHoldRead;
    logic txHoldWrite;
    logic rxRst;
    logic txRst;
    logic [7:0] txData;
  } ufc_state_t;

  ufc_state_t s;
  ufc_state_t next_s;

  logic enhOn;
  logic arTake;
  logic wrExec;
  logic rhrRead;
  logic [COUNT_W-1:0] rxTrigLvl;
  logic [COUNT_W-1:0] txTrigLvl;
  logic rxLevel;
  logic lsrP, toP, rxP, txP, msrP, xoffP, flowP;
  logic [5:0] isrCode;
  logic [7:0] isrValue;
  logic txFire;
  logic [6:0] charBits;
  logic [6:0] toLimit;
  logic toSet;
  logic [7:0] dataMask;

  function automatic logic parityOf(input logic [7:0] d, input logic [7:0] m,
                                    input logic [7:0] l);
    if (l[ufc_pkg::LCR_STICK]) parityOf = ~l[ufc_pkg::LCR_EVEN];
    else if (l[ufc_pkg::LCR_EVEN]) parityOf = ^(d & m);
    else parityOf = ~^(d & m);
  endfunction : parityOf

  assign enhOn = s.enh[ufc_pkg::ENH_EN];
  assign s_axi_awready = !s.awPend && !s.bValid;
  assign s_axi_wready = !s.wPend && !s.bValid;
  assign s_axi_arready = !s.rValid;
  assign arTake = s_axi_arvalid && !s.rValid;
  assign wrExec = s.awPend && s.wPend && !s.bValid;
  assign rhrRead = arTake && s_axi_araddr == ufc_pkg::ADDR_DATA &&
                   !s.line_format[ufc_pkg::LCR_DIV];

  // Non-FIFO mode behaves as a one-deep holding register
  assign rxTrigLvl = s.fifoEn ?
    COUNT_W'(ufc_pkg::trig_level(s.rxTrig)) : COUNT_W'(1);
  assign txTrigLvl = s.fifoEn ?
    COUNT_W'(ufc_pkg::trig_level(s.txTrig)) : COUNT_W'(1);
  assign rxLevel = rxCount >= rxTrigLvl;

  assign lsrP = s.lsrInt && s.ier[ufc_pkg::IER_LSR];
  assign toP = s.toInt && s.ier[ufc_pkg::IER_RX];
  assign rxP = rxLevel && s.ier[ufc_pkg::IER_RX];
  assign txP = s.txInt && s.ier[ufc_pkg::IER_TX];
  assign msrP = s.msrInt && s.ier[ufc_pkg::IER_MSR];
  assign xoffP = (s.xoffInt || s.specInt) && s.ier[ufc_pkg::IER_XOFF] &&
                 enhOn;
  assign flowP = s.flowInt && enhOn &&
    (s.ier[ufc_pkg::IER_RTS] || s.ier[ufc_pkg::IER_CTS]);

  always_comb begin
    if (lsrP) isrCode = ufc_pkg::ISR_LSR;
    else if (toP) isrCode = ufc_pkg::ISR_TO;
    else if (rxP) isrCode = ufc_pkg::ISR_RX;
    else if (txP) isrCode = ufc_pkg::ISR_TX;
    else if (msrP) isrCode = ufc_pkg::ISR_MSR;
    else if (xoffP) isrCode = ufc_pkg::ISR_XOFF;
    else if (flowP) isrCode = ufc_pkg::ISR_FLOW;
    else isrCode = ufc_pkg::ISR_NONE;
  end
  assign isrValue = {{2{s.fifoEn}}, isrCode};

  // Falling below the trigger, or emptying after a short reload
  assign txFire = (s.txOver && s.txPrev >= txTrigLvl &&
                   txCount < txTrigLvl) ||
                  (!s.txOver && s.txPrev != '0 && txCount == '0);

  assign charBits = 7'(dataBits) + 7'h1 + 7'(s.line_format[ufc_pkg::LCR_PEN]) +
                    (s.line_format[ufc_pkg::LCR_STOP] ? 7'h2 : 7'h1);
  assign toLimit = 7'(ufc_pkg::TO_CHARS * charBits) + ufc_pkg::TO_BITS;
  assign toSet = s.fifoEn && rxCount != '0 && s.toCount == toLimit &&
                 !rxActivity && !rhrRead;

  always_comb begin
    next_s = s;
    next_s.rxHoldRead = 1'b0;
    next_s.txHoldWrite = 1'b0;
    next_s.rxRst = 1'b0;
    next_s.txRst = 1'b0;
    if (s.bValid && s_axi_bready) next_s.bValid = 1'b0;
    if (s.rValid && s_axi_rready) next_s.rValid = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.awPend = 1'b1;
      next_s.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.wPend = 1'b1;
      next_s.wData = s_axi_wdata[7:0];
      next_s.wLane0 = s_axi_wstrb[0];
    end

    if (arTake) begin
      next_s.rValid = 1'b1;
      next_s.rResp = ufc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ufc_pkg::ADDR_DATA: begin
          if (s.line_format[ufc_pkg::LCR_DIV]) begin
            next_s.rData = s.divLow;
          end else begin
            next_s.rData = rxHoldData;
            next_s.rxHoldRead = 1'b1;
            next_s.toInt = 1'b0;
          end
        end
        ufc_pkg::ADDR_IER:
          next_s.rData = s.line_format[ufc_pkg::LCR_DIV] ? s.divHigh : s.ier;
        ufc_pkg::ADDR_ISR: begin
          next_s.rData = isrValue;
          if (isrCode == ufc_pkg::ISR_TX) next_s.txInt = 1'b0;
          if (isrCode == ufc_pkg::ISR_XOFF) begin
            next_s.xoffInt = 1'b0;
            next_s.specInt = 1'b0;
          end
        end
        ufc_pkg::ADDR_LCR: next_s.rData = s.line_format;
        ufc_pkg::ADDR_MCR: next_s.rData = s.modem_output_control;
        ufc_pkg::ADDR_LSR: begin
          next_s.rData = lineStatus;
          next_s.lsrInt = 1'b0;
        end
        ufc_pkg::ADDR_MSR: begin
          next_s.rData = modemStatus;
          next_s.msrInt = 1'b0;
          next_s.flowInt = 1'b0;
        end
        ufc_pkg::ADDR_ENH: next_s.rData = s.enh;
        default: begin
          next_s.rData = 8'h00;
          next_s.rResp = ufc_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (wrExec) begin
      next_s.awPend = 1'b0;
      next_s.wPend = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = ufc_pkg::RESP_OKAY;
      case (s.awAddr)
        ufc_pkg::ADDR_DATA: if (s.wLane0) begin
          if (s.line_format[ufc_pkg::LCR_DIV]) begin
            next_s.divLow = s.wData;
          end else begin
            next_s.txHoldWrite = 1'b1;
            next_s.txData = s.wData;
            next_s.txInt = 1'b0;
          end
        end
        ufc_pkg::ADDR_IER: if (s.wLane0) begin
          if (s.line_format[ufc_pkg::LCR_DIV]) begin
            next_s.divHigh = s.wData;
          end else begin
            next_s.ier = enhOn ? s.wData : {s.ier[7:4], s.wData[3:0]};
            // Enabling with an empty transmitter raises the interrupt
            if (s.wData[ufc_pkg::IER_TX] && !s.ier[ufc_pkg::IER_TX] &&
                txCount == '0) next_s.txInt = 1'b1;
          end
        end
        ufc_pkg::ADDR_ISR: if (s.wLane0) begin
          next_s.fifoEn = s.wData[ufc_pkg::FCR_EN];
          if (s.wData[ufc_pkg::FCR_EN]) begin
            next_s.rxRst = s.wData[ufc_pkg::FCR_RXRST];
            next_s.txRst = s.wData[ufc_pkg::FCR_TXRST];
            next_s.dma = s.wData[ufc_pkg::FCR_DMA];
            next_s.rxTrig = s.wData[7:6];
            if (enhOn) next_s.txTrig = s.wData[5:4];
          end
        end
        ufc_pkg::ADDR_LCR: if (s.wLane0) next_s.line_format = s.wData;
        ufc_pkg::ADDR_MCR: if (s.wLane0) next_s.modem_output_control = s.wData;
        ufc_pkg::ADDR_ENH: if (s.wLane0) next_s.enh = s.wData;
        ufc_pkg::ADDR_LSR, ufc_pkg::ADDR_MSR: next_s.bResp = ufc_pkg::RESP_OKAY;
        default: next_s.bResp = ufc_pkg::RESP_SLVERR;
      endcase
    end

    // Receive idle timer in bit times
    if (rxActivity || rhrRead || rxCount == '0) next_s.toCount = 7'h00;
    else if (bitTick && s.toCount != toLimit)
      next_s.toCount = s.toCount + 7'h01;

    next_s.txPrev = txCount;
    if (txFire) next_s.txOver = 1'b0;
    else if (txCount > txTrigLvl) next_s.txOver = 1'b1;

    // Clears from the far side, then sets; a set always wins
    if (xonMatch) next_s.xoffInt = 1'b0;
    if (rxCharEvent) next_s.specInt = 1'b0;
    if (lineErrEvent) next_s.lsrInt = 1'b1;
    if (toSet) next_s.toInt = 1'b1;
    if (txFire) next_s.txInt = 1'b1;
    if (modemDeltaEvent) next_s.msrInt = 1'b1;
    if (xoffMatch) next_s.xoffInt = 1'b1;
    if (specialMatch) next_s.specInt = 1'b1;
    if (flowDeassert) next_s.flowInt = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.ier <= ufc_pkg::IER_RESET;
      s.line_format <= ufc_pkg::LCR_RESET;
      s.modem_output_control <= ufc_pkg::MCR_RESET;
      s.enh <= ufc_pkg::ENH_RESET;
      s.divLow <= ufc_pkg::DIV_RESET;
      s.divHigh <= ufc_pkg::DIV_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rresp = s.rResp;
  assign s_axi_rdata = {24'h000000, s.rData};
  assign rxHoldRead = s.rxHoldRead;
  assign txHoldWrite = s.txHoldWrite;
  assign txHoldData = s.txData;
  assign rxFifoReset = s.rxRst;
  assign txFifoReset = s.txRst;
  assign fifoEnable = s.fifoEn;
  assign dataBits = 4'h5 + {2'h0, s.line_format[1:0]};
  assign stopHalfBits = !s.line_format[ufc_pkg::LCR_STOP] ? 3'h2 :
                        (s.line_format[1:0] == 2'h0 ? 3'h3 : 3'h4);
  assign parityEnable = s.line_format[ufc_pkg::LCR_PEN];
  assign dataMask = 8'hff >> (4'h8 - dataBits);
  assign txParityBit = parityOf(txParityData, dataMask, s.line_format);
  assign rxParityError = parityEnable &&
    rxParityBit != parityOf(rxParityData, dataMask, s.line_format);
  assign txPin = s.line_format[ufc_pkg::LCR_BREAK] ? 1'b0 : txSerial;
  assign dtrN = ~s.modem_output_control[ufc_pkg::MCR_DTR];
  assign rtsN = ~s.modem_output_control[ufc_pkg::MCR_RTS];
  assign rxReadyN = s.dma ? !(rxLevel || s.toInt) : rxCount == '0;
  assign txReadyN = s.dma ? txCount == COUNT_W'(FIFO_DEPTH) :
                    txCount != '0;
  assign loopback = s.modem_output_control[ufc_pkg::MCR_LOOP];
  // Normalised to an active-high pulse for the decoder
  assign irdaRxData = (s.modem_output_control[ufc_pkg::MCR_IRDA] && enhOn &&
                       !s.modem_output_control[ufc_pkg::MCR_IRPOL]) ? ~irdaRxIn : irdaRxIn;
  assign ringStatus = loopback ? s.modem_output_control[ufc_pkg::MCR_IRPOL] :
                      ~ringIndicatorInN;
  assign divisor = {s.divHigh, s.divLow};

  a_lsr_clear: assert property (@(posedge sys_clk) disable iff (rst)
    arTake && s_axi_araddr == ufc_pkg::ADDR_LSR && !lineErrEvent
    |=> !s.lsrInt) else $error("line status flag not cleared");
  a_rx_pending: assert property (@(posedge sys_clk) disable iff (rst)
    rxP |-> !isrValue[0] && isrCode != ufc_pkg::ISR_MSR)
    else $error("receive level not reported");
  a_to_clear: assert property (@(posedge sys_clk) disable iff (rst)
    rhrRead |=> !s.toInt && s.rxHoldRead)
    else $error("timeout not cleared by read");
  a_tx_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wrExec && s.wLane0 && s.awAddr == ufc_pkg::ADDR_DATA &&
    !s.line_format[ufc_pkg::LCR_DIV] && !txFire |=> !s.txInt && txHoldWrite)
    else $error("transmit flag not cleared");
  a_msr_clear: assert property (@(posedge sys_clk) disable iff (rst)
    arTake && s_axi_araddr == ufc_pkg::ADDR_MSR && !flowDeassert &&
    !modemDeltaEvent |=> !s.flowInt && !s.msrInt)
    else $error("modem flags not cleared");
  a_isr_none: assert property (@(posedge sys_clk) disable iff (rst)
    !(lsrP || toP || rxP || txP || msrP || xoffP || flowP)
    |-> isrValue[5:0] == ufc_pkg::ISR_NONE)
    else $error("idle code wrong");
  a_isr_enh: assert property (@(posedge sys_clk) disable iff (rst)
    !enhOn |-> isrValue[5:4] == 2'h0)
    else $error("enhanced bits shown while off");
  a_fcr_ignore: assert property (@(posedge sys_clk) disable iff (rst)
    wrExec && s.wLane0 && s.awAddr == ufc_pkg::ADDR_ISR && !s.wData[0]
    |=> $stable(s.rxTrig) && !rxFifoReset && !fifoEnable)
    else $error("FIFO setup taken without enable");
  a_break_low: assert property (@(posedge sys_clk) disable iff (rst)
    s.line_format[ufc_pkg::LCR_BREAK] |-> !txPin)
    else $error("break not held low");
  a_div_route: assert property (@(posedge sys_clk) disable iff (rst)
    wrExec && s.line_format[ufc_pkg::LCR_DIV] && s.awAddr == ufc_pkg::ADDR_DATA
    |=> !txHoldWrite) else $error("divisor write leaked");
endmodule : ufc_uart_ctrl
`default_nettype wire

// ==== bench/ufc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ufc_host_model (
  input wire logic sys_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic fin;
    fin = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!fin) begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        fin = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : ufc_host_model
`default_nettype wire

// ==== bench/uart_interrupt_fifo_line_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module uart_interrupt_fifo_line_control_tb;
  typedef struct packed {
    logic [7:0] line_format;
    logic [3:0] bits;
    logic [2:0] stop;
    logic pen;
    logic par;
  } ufc_row_t;
  localparam ufc_row_t ROWS [7] = '{
    '{8'h00, 4'h5, 3'h2, 1'b0, 1'b0}, '{8'h04, 4'h5, 3'h3, 1'b0, 1'b0},
    '{8'h05, 4'h6, 3'h4, 1'b0, 1'b0}, '{8'h0a, 4'h7, 3'h2, 1'b1, 1'b0},
    '{8'h1b, 4'h8, 3'h2, 1'b1, 1'b1}, '{8'h2b, 4'h8, 3'h2, 1'b1, 1'b1},
    '{8'h3f, 4'h8, 3'h4, 1'b1, 1'b0}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr, txHoldData;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, dataBits;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] rxHoldData = 8'h5c, lineStatus = 8'h02, modemStatus = 8'h01;
  logic [7:0] txParityData = 8'h01, rxParityData = 8'h01, rdv;
  logic [4:0] rxCount = 5'h00, txCount = 5'h00;
  logic rxCharEvent = 1'b0, rxActivity = 1'b0, lineErrEvent = 1'b0;
  logic modemDeltaEvent = 1'b0, xoffMatch = 1'b0, xonMatch = 1'b0;
  logic specialMatch = 1'b0, flowDeassert = 1'b0, bitTick = 1'b0;
  logic txSerial = 1'b1, rxParityBit = 1'b0, ringIndicatorInN = 1'b1;
  logic irdaRxIn = 1'b0;
  logic rxHoldRead, txHoldWrite, rxFifoReset, txFifoReset, fifoEnable;
  logic parityEnable, txParityBit, rxParityError, txPin, dtrN, rtsN;
  logic txReadyN, rxReadyN, irdaRxData, loopback, ringStatus;
  logic [2:0] stopHalfBits;
  logic [15:0] divisor;
  int errors = 0;
  int comparisons = 0;
  int rxRst = 0;
  int txRst = 0;
  int txHw = 0;
  int rxHr = 0;

  always #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (rxFifoReset === 1'b1) rxRst <= rxRst + 1;
    if (txFifoReset === 1'b1) txRst <= txRst + 1;
    if (txHoldWrite === 1'b1) txHw <= txHw + 1;
    if (rxHoldRead === 1'b1) rxHr <= rxHr + 1;
  end

  ufc_uart_ctrl ufc_uart_ctrl_i (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxHoldData(rxHoldData),
    .lineStatus(lineStatus), .modemStatus(modemStatus), .rxCount(rxCount),
    .txCount(txCount), .rxCharEvent(rxCharEvent), .rxActivity(rxActivity),
    .lineErrEvent(lineErrEvent), .modemDeltaEvent(modemDeltaEvent),
    .xoffMatch(xoffMatch), .xonMatch(xonMatch), .specialMatch(specialMatch),
    .flowDeassert(flowDeassert), .bitTick(bitTick), .txSerial(txSerial),
    .txParityData(txParityData), .rxParityData(rxParityData),
    .rxParityBit(rxParityBit), .ringIndicatorInN(ringIndicatorInN),
    .irdaRxIn(irdaRxIn), .rxHoldRead(rxHoldRead), .txHoldWrite(txHoldWrite),
    .txHoldData(txHoldData), .rxFifoReset(rxFifoReset),
    .txFifoReset(txFifoReset), .fifoEnable(fifoEnable), .dataBits(dataBits),
    .stopHalfBits(stopHalfBits), .parityEnable(parityEnable),
    .txParityBit(txParityBit), .rxParityError(rxParityError), .txPin(txPin),
    .dtrN(dtrN), .rtsN(rtsN), .txReadyN(txReadyN), .rxReadyN(rxReadyN),
    .irdaRxData(irdaRxData), .loopback(loopback), .ringStatus(ringStatus),
    .divisor(divisor));

  ufc_host_model ufc_host_model_i (.sys_clk(sys_clk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    ufc_host_model_i.wr(a, d);
    @(negedge sys_clk);
    chk(bresp, ufc_pkg::RESP_OKAY);
  endtask : wrs

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    ufc_host_model_i.rd(a, rdv, rsp);
    chk(rdv, e);
    chk(rsp, ufc_pkg::RESP_OKAY);
  endtask : rdc

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #(40 * 20000);
    errors++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(dtrN, 1'b1);
    chk(rtsN, 1'b1);
    rdc(ufc_pkg::ADDR_ISR, 8'h01);
    rdc(ufc_pkg::ADDR_LCR, 8'h00);
    foreach (ROWS[i]) begin
      wrs(ufc_pkg::ADDR_LCR, ROWS[i].line_format);
      chk(dataBits, ROWS[i].bits);
      chk(stopHalfBits, ROWS[i].stop);
      chk(parityEnable, ROWS[i].pen);
      if (ROWS[i].pen) chk(txParityBit, ROWS[i].par);
      chk(rxParityError, ROWS[i].pen & ROWS[i].par);
      rdc(ufc_pkg::ADDR_LCR, ROWS[i].line_format);
    end
    wrs(ufc_pkg::ADDR_MCR, 8'h13);
    chk({dtrN, rtsN, loopback, ringStatus}, 4'h2);
    wrs(ufc_pkg::ADDR_MCR, 8'h14);
    chk({dtrN, rtsN, loopback, ringStatus}, 4'hf);
    rdc(ufc_pkg::ADDR_MCR, 8'h14);
    wrs(ufc_pkg::ADDR_MCR, 8'h00);
    wrs(ufc_pkg::ADDR_LCR, 8'h43);
    repeat (4) @(negedge sys_clk);
    chk(txPin, 1'b0);
    wrs(ufc_pkg::ADDR_LCR, 8'h03);
    chk(txPin, 1'b1);
    wrs(ufc_pkg::ADDR_LCR, 8'h83);
    wrs(ufc_pkg::ADDR_DATA, 8'h34);
    wrs(ufc_pkg::ADDR_IER, 8'h12);
    chk(divisor, 16'h1234);
    chk(txHw, 0);
    wrs(ufc_pkg::ADDR_LCR, 8'h03);
    wrs(ufc_pkg::ADDR_DATA, 8'ha5);
    chk(txHoldData, 8'ha5);
    chk(txHw, 1);
    wrs(ufc_pkg::ADDR_ISR, 8'h06);
    chk(fifoEnable, 1'b0);
    chk(rxRst + txRst, 0);
    rdc(ufc_pkg::ADDR_ISR, 8'h01);
    wrs(ufc_pkg::ADDR_ISR, 8'h07);
    chk(fifoEnable, 1'b1);
    chk({rxRst[15:0], txRst[15:0]}, 32'h00010001);
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    chk({rxRst[15:0], txRst[15:0]}, 32'h00010001);
    @(posedge sys_clk);
    rxCount <= 5'h01;
    @(negedge sys_clk);
    chk(rxReadyN, 1'b0);
    wrs(ufc_pkg::ADDR_ISR, 8'h49);
    chk({rxReadyN, txReadyN}, 2'h2);
    @(posedge sys_clk);
    rxCount <= 5'h04;
    @(negedge sys_clk);
    chk(rxReadyN, 1'b0);
    @(posedge sys_clk);
    rxCount <= 5'h00;
    txCount <= 5'h10;
    @(negedge sys_clk);
    chk(txReadyN, 1'b1);
    @(posedge sys_clk);
    txCount <= 5'h00;
    wrs(ufc_pkg::ADDR_ISR, 8'h01);
    wrs(ufc_pkg::ADDR_IER, 8'h0f);
    @(posedge sys_clk);
    lineErrEvent <= 1'b1;
    modemDeltaEvent <= 1'b1;
    @(posedge sys_clk);
    lineErrEvent <= 1'b0;
    modemDeltaEvent <= 1'b0;
    rdc(ufc_pkg::ADDR_ISR, 8'hc6);
    rdc(ufc_pkg::ADDR_ISR, 8'hc6);
    rdc(ufc_pkg::ADDR_LSR, 8'h02);
    rdc(ufc_pkg::ADDR_ISR, 8'hc2);
    rdc(ufc_pkg::ADDR_ISR, 8'hc0);
    rdc(ufc_pkg::ADDR_MSR, 8'h01);
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    @(posedge sys_clk);
    rxCount <= 5'h01;
    rdc(ufc_pkg::ADDR_ISR, 8'hc4);
    rdc(ufc_pkg::ADDR_ISR, 8'hc4);
    @(posedge sys_clk);
    rxCount <= 5'h00;
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    wrs(ufc_pkg::ADDR_IER, 8'h0d);
    wrs(ufc_pkg::ADDR_IER, 8'h0f);
    @(posedge sys_clk);
    txCount <= 5'h01;
    wrs(ufc_pkg::ADDR_DATA, 8'h5a);
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    @(posedge sys_clk);
    xoffMatch <= 1'b1;
    flowDeassert <= 1'b1;
    @(posedge sys_clk);
    xoffMatch <= 1'b0;
    flowDeassert <= 1'b0;
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    wrs(ufc_pkg::ADDR_ISR, 8'h81);
    @(posedge sys_clk);
    rxCount <= 5'h04;
    bitTick <= 1'b1;
    // Four 10-bit chars plus 12 bits is 52 ticks; stop one short
    repeat (51) @(posedge sys_clk);
    bitTick <= 1'b0;
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    @(posedge sys_clk);
    bitTick <= 1'b1;
    @(posedge sys_clk);
    bitTick <= 1'b0;
    rdc(ufc_pkg::ADDR_ISR, 8'hcc);
    rdc(ufc_pkg::ADDR_DATA, 8'h5c);
    @(negedge sys_clk);
    chk(rxHr, 1);
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    wrs(ufc_pkg::ADDR_ENH, 8'h10);
    wrs(ufc_pkg::ADDR_IER, 8'h20);
    rdc(ufc_pkg::ADDR_ISR, 8'hd0);
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    wrs(ufc_pkg::ADDR_IER, 8'h40);
    rdc(ufc_pkg::ADDR_ISR, 8'he0);
    rdc(ufc_pkg::ADDR_MSR, 8'h01);
    rdc(ufc_pkg::ADDR_ISR, 8'hc1);
    wrs(ufc_pkg::ADDR_MCR, 8'h43);
    chk({dtrN, rtsN, irdaRxData}, 3'h1);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({dtrN, rtsN, fifoEnable, irdaRxData}, 4'hc);
    rdc(ufc_pkg::ADDR_ISR, 8'h01);
    ufc_host_model_i.rd(8'h20, rdv, rsp);
    chk({rsp, rdv}, {ufc_pkg::RESP_SLVERR, 8'h00});
    end_of_test();
  end
endmodule : uart_interrupt_fifo_line_control_tb
`default_nettype wire
